// [design/cwo_top.sv]
// Register access over AHB-Lite and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
module cwo_top #(
  parameter int unsigned LONG_START_CYCLES = cwo_pkg::LONG_CYC_DFLT
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Nonvolatile storage image
  input  wire logic [11:0] nv_config_word,
  input  wire logic [11:0] nv_calib_word,
  // Device settings
  output logic             reset_timer_enable,
  output logic             brownout_reset_enable,
  output logic             selfwrite_memory_protect,
  output logic             program_memory_protect,
  output logic             internal_osc_frequency_select,
  output logic             watchdog_enable,
  output logic [5:0]       clock_source_onehot,
  output logic [6:0]       oscillator_trim,
  // Master clear pin
  input  wire logic        master_clear_reset_pin_n,
  output logic             master_clear_reset,
  output logic             port_a_bit3_in,
  // Second oscillator pin
  input  wire logic        osc2_in,
  output logic             osc2_out,
  output logic             osc2_oe,
  input  wire logic        clock_output_function_src,
  input  wire logic        port_a_bit4_out,
  input  wire logic        port_a_bit4_oe,
  output logic             port_a_bit4_in,
  // Core boot view
  output logic             core_reset,
  output logic [9:0]       boot_pc,
  output logic [7:0]       boot_accumulator
);

  cwo_pkg::cwo_top_s s_q;
  cwo_pkg::cwo_top_s s_d;
  cwo_timer_if       tmr_if ();

  logic [5:0]  mode_1h;
  logic        long_delay;
  logic        clock_output_function_mode;
  logic        port4_mode;
  logic        master_clear_reset_act;
  logic        addr_ok;
  logic [11:0] cfg_view;
  logic [31:0] status_word;

  // Maps the mode field to one clock source flag
  function automatic logic [5:0] decode_mode(input logic [2:0] fld);
    logic [5:0] oh;
    oh = 6'h00;
    unique case (fld)
      3'h0:       oh[cwo_pkg::M_LP]    = 1'b1;
      3'h1:       oh[cwo_pkg::M_XT]    = 1'b1;
      3'h2:       oh[cwo_pkg::M_HS]    = 1'b1;
      3'h3:       oh[cwo_pkg::M_EC]    = 1'b1;
      3'h4, 3'h5: oh[cwo_pkg::M_INTERNAL_RC_OSCILLATOR] = 1'b1;
      3'h6, 3'h7: oh[cwo_pkg::M_EXTERNAL_RC_OSCILLATOR] = 1'b1;
    endcase
    return oh;
  endfunction

  // Crystal modes need the long delay regardless of the enable bit
  function automatic logic is_crystal(input logic [5:0] oh);
    return oh[cwo_pkg::M_LP] | oh[cwo_pkg::M_XT] | oh[cwo_pkg::M_HS];
  endfunction

  // Register read multiplexer, zero for unmapped offsets
  function automatic logic [31:0] read_reg(input logic [11:0] a, input logic [11:0] cv, input logic [7:0] tr,
                                           input logic [31:0] st, input logic [11:0] cal, input logic [7:0] ac,
                                           input logic [9:0] pc);
    logic [31:0] r;
    r = 32'h00000000;
    if (a == cwo_pkg::OFS_CONFIG) begin
      r = {20'h00000, cv};
    end else if (a == cwo_pkg::OFS_TRIM) begin
      r = {24'h000000, tr[7:1], 1'b0};
    end else if (a == cwo_pkg::OFS_STATUS) begin
      r = st;
    end else if (a == cwo_pkg::OFS_CALIB) begin
      r = {20'h00000, cal};
    end else if (a == cwo_pkg::OFS_BOOT) begin
      r = {14'h0000, pc, ac};
    end
    return r;
  endfunction

  assign mode_1h    = decode_mode(s_q.cfg[2:0]);
  assign long_delay = is_crystal(mode_1h) | s_q.cfg[cwo_pkg::BIT_RST_TMR];
  // odd RC codes drive the clock out
  assign clock_output_function_mode = (mode_1h[cwo_pkg::M_INTERNAL_RC_OSCILLATOR] | mode_1h[cwo_pkg::M_EXTERNAL_RC_OSCILLATOR]) & s_q.cfg[0];
  // port bit on the second pin
  assign port4_mode  = mode_1h[cwo_pkg::M_EC] | ((mode_1h[cwo_pkg::M_INTERNAL_RC_OSCILLATOR] | mode_1h[cwo_pkg::M_EXTERNAL_RC_OSCILLATOR])
                       & ~s_q.cfg[0]);
  // pin acts as reset only when enabled
  assign master_clear_reset_act    = s_q.cfg[cwo_pkg::BIT_MASTER_CLEAR_RESET_EN] & ~master_clear_reset_pin_n;

  assign cfg_view = {cwo_pkg::CFG_UNIMP, s_q.cfg[9:0]};

  // Status word gathers live block state
  always_comb begin
    status_word = 32'h00000000;
    status_word[cwo_pkg::ST_RUN]       = (s_q.phase == cwo_pkg::PH_RUN);
    status_word[cwo_pkg::ST_TMR_BUSY]  = tmr_if.busy;
    status_word[cwo_pkg::ST_LONG]      = long_delay;
    status_word[cwo_pkg::ST_MASTER_CLEAR_RESET]      = master_clear_reset_act;
    status_word[cwo_pkg::ST_SW_PROT]   = ~s_q.cfg[cwo_pkg::BIT_SW_PROT];
    status_word[cwo_pkg::ST_PROG_PROT] = ~s_q.cfg[cwo_pkg::BIT_PROG_PROT];
    status_word[cwo_pkg::ST_MODE_LSB +: 3] = s_q.cfg[2:0];
  end

  // Only the low 4 KB window decodes; higher addresses alias nothing
  assign addr_ok = (haddr[31:12] == 20'h00000);

  // Next-state logic: boot sequence and bus slave
  always_comb begin
    s_d       = s_q;
    s_d.start = 1'b0;

    unique case (s_q.phase)
      cwo_pkg::PH_LOAD: begin
        s_d.cfg   = nv_config_word;
        s_d.calib = nv_calib_word;
        s_d.start = 1'b1;
        s_d.phase = cwo_pkg::PH_STARTUP;
      end
      cwo_pkg::PH_STARTUP: begin
        if (tmr_if.done && !master_clear_reset_act) begin
          s_d.phase = cwo_pkg::PH_BOOT;
        end
      end
      cwo_pkg::PH_BOOT: begin
        // execute load-literal from the last address
        s_d.accum = s_q.calib[7:0];
        // wrap to the user program start
        s_d.pc    = cwo_pkg::PROG_START;
        s_d.phase = cwo_pkg::PH_RUN;
      end
      cwo_pkg::PH_RUN: begin
      end
    endcase

    // master clear restarts start-up, settings stay latched
    if (master_clear_reset_act && s_q.phase != cwo_pkg::PH_LOAD) begin
      s_d.start = 1'b1;
      s_d.phase = cwo_pkg::PH_STARTUP;
      s_d.pc    = cwo_pkg::PROG_LAST_ADDR;
    end

    // Write data phase
    if (s_q.wr_pend) begin
      s_d.wr_pend = 1'b0;
      if (s_q.wr_addr == cwo_pkg::OFS_TRIM) begin
        // trim takes bits 7 to 1 only
        s_d.trim = {hwdata[7:1], 1'b0};
      end
    end

    // Address phase
    if (hsel && htrans[1] && hready) begin
      s_d.wr_pend = hwrite & addr_ok;
      s_d.wr_addr = haddr[11:0];
      s_d.rdata   = (!hwrite && addr_ok) ?
                    read_reg(haddr[11:0], cfg_view, s_d.trim, status_word, s_q.calib, s_q.accum, s_q.pc) :
                    32'h00000000;
    end
  end

  // Single state register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_q.phase   <= cwo_pkg::PH_LOAD;
      s_q.start   <= 1'b0;
      s_q.cfg     <= cwo_pkg::CFG_RESET;
      s_q.calib   <= cwo_pkg::CALIB_RESET;
      s_q.trim    <= cwo_pkg::TRIM_RESET;
      s_q.accum   <= cwo_pkg::ACCUM_RESET;
      s_q.pc      <= cwo_pkg::PROG_LAST_ADDR;
      s_q.wr_pend <= 1'b0;
      s_q.wr_addr <= 12'h000;
      s_q.rdata   <= 32'h00000000;
    end else begin
      s_q <= s_d;
    end
  end

  assign tmr_if.start       = s_q.start;
  assign tmr_if.load_cycles = long_delay ? cwo_pkg::TIMER_W'(LONG_START_CYCLES) : cwo_pkg::SHORT_CYCLES;

  cwo_startup_timer u_timer (
    .ref_clk (ref_clk),
    .rst     (rst),
    .tmr     (tmr_if)
  );

  // Zero-wait slave, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = s_q.rdata;

  assign reset_timer_enable            = s_q.cfg[cwo_pkg::BIT_RST_TMR];
  assign brownout_reset_enable         = s_q.cfg[cwo_pkg::BIT_BROWNOUT];
  // region protected when the bit is zero
  assign selfwrite_memory_protect      = ~s_q.cfg[cwo_pkg::BIT_SW_PROT];
  assign program_memory_protect        = ~s_q.cfg[cwo_pkg::BIT_PROG_PROT];
  // one selects the 8 MHz rate
  assign internal_osc_frequency_select = s_q.cfg[cwo_pkg::BIT_OSC_FREQ];
  assign watchdog_enable               = s_q.cfg[cwo_pkg::BIT_WDT_EN];
  assign clock_source_onehot           = mode_1h;
  assign oscillator_trim               = s_q.trim[7:1];

  // pin either resets or reads as a port input
  assign master_clear_reset = master_clear_reset_act;
  assign port_a_bit3_in     = s_q.cfg[cwo_pkg::BIT_MASTER_CLEAR_RESET_EN] ? 1'b0 : master_clear_reset_pin_n;

  // Second pin: clock out, port bit, or left to the crystal
  always_comb begin
    osc2_out       = 1'b0;
    osc2_oe        = 1'b0;
    port_a_bit4_in = 1'b0;
    if (clock_output_function_mode) begin
      osc2_out = clock_output_function_src;
      osc2_oe  = 1'b1;
    end else if (port4_mode) begin
      osc2_out       = port_a_bit4_out;
      osc2_oe        = port_a_bit4_oe;
      port_a_bit4_in = osc2_in;
    end
  end

  // Core held until start-up and boot complete
  assign core_reset       = (s_q.phase != cwo_pkg::PH_RUN) | master_clear_reset_act;
  assign boot_pc          = s_q.pc;
  assign boot_accumulator = s_q.accum;

endmodule

// [inc/cwo_pkg.sv]
// Function
// - Configuration word is twelve bits; bits 11 and 10 always read as one.
// - Bit 9 enables the reset timer; bit 8 enables brown-out reset.
// - Bit 7 protects self-writable data memory, apart from program protection.
// - Bit 6 selects between the two internal oscillator rates.
// - Bit 5 one: pin is active-low master clear; zero: port input, reset inactive.
// - Bit 4 one turns program memory protection off, zero turns it on.
// - Bit 3 one enables the watchdog, zero disables it.
// - Bits 2 to 0 pick one of six clock source modes.
// - Codes 000 to 010 are crystal modes, always with the long start-up delay.
// - Code 011 is external clock; second pin is port bit; short start-up.
// - Codes 100/101 internal RC, short start-up; 100 port bit, 101 clock out.
// - Codes 110/111 external RC, short start-up; 110 port bit, 111 clock out.
// - Reset timer enable lengthens the short start-up delay to the long one.
// - Last program address holds a load-literal of the calibration value, run first.
// - After that instruction the program counter wraps to 0x000, value kept.
// - Calibration word stays readable whatever the protection settings.
// - Writing the trim register adjusts the internal oscillator frequency.
// - Only trim bits 7 to 1 take part; bit 0 is unimplemented.
package cwo_pkg;

  // Configuration word layout
  localparam int          CFG_W          = 12;
  localparam int          BIT_RST_TMR    = 9;
  localparam int          BIT_BROWNOUT   = 8;
  localparam int          BIT_SW_PROT    = 7;
  localparam int          BIT_OSC_FREQ   = 6;
  localparam int          BIT_MASTER_CLEAR_RESET_EN    = 5;
  localparam int          BIT_PROG_PROT  = 4;
  localparam int          BIT_WDT_EN     = 3;
  localparam logic [11:0] CFG_RESET      = 12'hFFF;
  localparam logic [1:0]  CFG_UNIMP      = 2'h3;

  // Calibration and boot
  localparam logic [11:0] CALIB_RESET    = 12'hC00;
  localparam logic [9:0]  PROG_LAST_ADDR = 10'h3FF;
  localparam logic [9:0]  PROG_START     = 10'h000;
  localparam logic [7:0]  TRIM_RESET     = 8'h00;
  localparam logic [7:0]  ACCUM_RESET    = 8'h00;

  // Register byte offsets
  localparam logic [11:0] OFS_CONFIG     = 12'h000;
  localparam logic [11:0] OFS_TRIM       = 12'h004;
  localparam logic [11:0] OFS_STATUS     = 12'h008;
  localparam logic [11:0] OFS_CALIB      = 12'h00C;
  localparam logic [11:0] OFS_BOOT       = 12'h010;

  // Status register fields
  localparam int          ST_RUN         = 0;
  localparam int          ST_TMR_BUSY    = 1;
  localparam int          ST_LONG        = 2;
  localparam int          ST_MASTER_CLEAR_RESET        = 3;
  localparam int          ST_SW_PROT     = 4;
  localparam int          ST_PROG_PROT   = 5;
  localparam int          ST_MODE_LSB    = 8;

  // Start-up timing at 40 MHz
  localparam int          CLK_PERIOD_NS  = 25;
  localparam int          LONG_DELAY_MS  = 18;
  localparam int          SHORT_DELAY_US = 10;
  localparam int          TIMER_W        = 20;
  localparam int          LONG_CYC_DFLT  = (LONG_DELAY_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [19:0] SHORT_CYCLES   = 20'((SHORT_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Clock source one-hot positions
  localparam int          M_LP           = 0;
  localparam int          M_XT           = 1;
  localparam int          M_HS           = 2;
  localparam int          M_EC           = 3;
  localparam int          M_INTERNAL_RC_OSCILLATOR        = 4;
  localparam int          M_EXTERNAL_RC_OSCILLATOR        = 5;

  typedef enum logic [1:0] {
    PH_LOAD,
    PH_STARTUP,
    PH_BOOT,
    PH_RUN
  } cwo_phase_e;

  typedef struct packed {
    cwo_phase_e  phase;
    logic        start;
    logic [11:0] cfg;
    logic [11:0] calib;
    logic [7:0]  trim;
    logic [7:0]  accum;
    logic [9:0]  pc;
    logic        wr_pend;
    logic [11:0] wr_addr;
    logic [31:0] rdata;
  } cwo_top_s;

  typedef struct packed {
    logic        busy;
    logic        done;
    logic [19:0] cnt;
  } cwo_timer_s;

endpackage

// [inc/cwo_timer_if.sv]
`timescale 1ns/100ps
interface cwo_timer_if;
  logic        start;
  logic [19:0] load_cycles;
  logic        busy;
  logic        done;

  modport ctrl  (output start, output load_cycles, input busy, input done);
  modport timer (input start, input load_cycles, output busy, output done);
endinterface

// [design/cwo_startup_timer.sv]
`timescale 1ns/100ps
module cwo_startup_timer (
  // Clock and reset
  input  wire logic   ref_clk,
  input  wire logic   rst,
  // Control from the loader
  cwo_timer_if.timer  tmr
);

  cwo_pkg::cwo_timer_s s_q;
  cwo_pkg::cwo_timer_s s_d;

  // Down counter; a new start restarts it even mid-count
  always_comb begin
    s_d      = s_q;
    s_d.done = 1'b0;
    if (tmr.start) begin
      s_d.busy = 1'b1;
      s_d.cnt  = (tmr.load_cycles == 20'h00000) ? 20'h00000 : tmr.load_cycles - 20'h00001;
    end else if (s_q.busy) begin
      if (s_q.cnt == 20'h00000) begin
        s_d.busy = 1'b0;
        s_d.done = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt - 20'h00001;
      end
    end
  end

  // State register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tmr.busy = s_q.busy;
  assign tmr.done = s_q.done;

endmodule

// [sim/cwo_props.sv]
`timescale 1ns/100ps
module cwo_props #(
  parameter int unsigned LONG_START_CYCLES = 50
) (
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        rst,
  // Bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // Settings and pins
  input wire logic        watchdog_enable,
  input wire logic [5:0]  clock_source_onehot,
  input wire logic [6:0]  oscillator_trim,
  input wire logic        master_clear_reset_pin_n,
  input wire logic        master_clear_reset,
  input wire logic        port_a_bit3_in,
  input wire logic        osc2_in,
  input wire logic        osc2_oe,
  input wire logic        port_a_bit4_oe,
  input wire logic        port_a_bit4_in,
  input wire logic        core_reset,
  input wire logic [9:0]  boot_pc
);
  // Shorter of the two start-up counts, since the long one is cut down in sim
  localparam int MIN_N = (LONG_START_CYCLES < 400) ? LONG_START_CYCLES : 400;
  logic [19:0] up_q;
  logic [19:0] up_d;
  logic [6:0]  w_trim;
  assign w_trim = hwdata[7:1];
  // Cycles since reset release, saturating
  always_comb up_d = (up_q == 20'hFFFFF) ? up_q : up_q + 20'h1;
  always_ff @(posedge ref_clk) up_q <= rst ? 20'h0 : up_d;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  bus_okay_a: assert property (hreadyout && !hresp) else $error("bus answer not ready or not okay");
  trim_load_a: assert property (hsel && htrans[1] && hready && hwrite && haddr == 32'h4 |->
    ##2 oscillator_trim == $past(w_trim)) else $error("trim does not follow written data");
  mode_onehot_a: assert property ($onehot(clock_source_onehot)) else $error("clock source not one-hot");
  crystal_pin_a: assert property (|clock_source_onehot[2:0] |-> !osc2_oe && !port_a_bit4_in)
    else $error("second pin active in crystal mode");
  ext_clk_pin_a: assert property (clock_source_onehot[3] |-> osc2_oe == port_a_bit4_oe
    && port_a_bit4_in == osc2_in) else $error("second pin not a port bit");
  clear_hold_a: assert property (master_clear_reset |-> core_reset && !master_clear_reset_pin_n && !port_a_bit3_in)
    else $error("master clear without core reset");
  pin_input_a: assert property (port_a_bit3_in |-> master_clear_reset_pin_n && !master_clear_reset)
    else $error("port input seen while pin is reset");
  boot_wrap_a: assert property (!core_reset |-> boot_pc == 10'h000) else $error("running away from address zero");
  cfg_hold_a: assert property (!$past(rst) && !$past(rst, 2) |-> $stable(clock_source_onehot)
    && $stable(watchdog_enable)) else $error("settings moved during operation");
  startup_min_a: assert property (!core_reset |-> up_q >= MIN_N) else $error("start-up delay too short");
  boot_c: cover property ($fell(core_reset));
  clear_c: cover property (master_clear_reset);
  clock_output_function_c: cover property (clock_source_onehot[5] && osc2_oe);
endmodule

bind cwo_top cwo_props #(.LONG_START_CYCLES(LONG_START_CYCLES)) u_props (.ref_clk, .rst, .hsel, .haddr,
  .htrans, .hwrite, .hwdata, .hready, .hreadyout, .hresp, .watchdog_enable, .clock_source_onehot,
  .oscillator_trim, .master_clear_reset_pin_n, .master_clear_reset, .port_a_bit3_in, .osc2_in, .osc2_oe,
  .port_a_bit4_oe, .port_a_bit4_in, .core_reset, .boot_pc);

// [sim/cwo_programmer.sv]
`timescale 1ns/100ps
module cwo_programmer #(
  parameter logic [11:0] CALIB_WORD = 12'hC5A
) (
  // Clock
  input wire logic        ref_clk,
  // Requests from the bench
  input wire logic        load,
  input wire logic [11:0] load_word,
  input wire logic        erase,
  // Storage image seen by the device
  output logic [11:0]     config_word,
  output logic [11:0]     calib_word
);
  logic [11:0] saved;
  initial begin
    config_word = 12'hFFF;
    calib_word  = CALIB_WORD;
  end
  // Programs the word; erase blanks it
  always @(posedge ref_clk) begin
    if (load)
      config_word <= load_word;
    if (erase) begin
      saved = calib_word;
      config_word <= 12'hFFF;
      calib_word  <= saved;
    end
  end
endmodule

// [sim/cwo_top_tb_top.sv]
`timescale 1ns/100ps
module cwo_top_tb_top;
  localparam int LONG_N = 50;
  localparam logic [11:0] CAL = 12'hC5A;
  typedef struct { logic [11:0] cfg; logic [5:0] hot; int n; } cwo_row_s;
  // One row for each oscillator mode code
  cwo_row_s rows [8] = '{'{12'h0F8, 6'h01, LONG_N}, '{12'h001, 6'h02, LONG_N}, '{12'h30A, 6'h04, LONG_N},
    '{12'hC53, 6'h08, 400}, '{12'h0A4, 6'h10, 400}, '{12'h265, 6'h10, LONG_N}, '{12'h11E, 6'h20, 400},
    '{12'h0E7, 6'h20, 400}};
  logic        ref_clk = 0, rst = 1, hsel = 0, hwrite = 0, load = 0, erase = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata;
  logic [1:0]  htrans = 0;
  logic [2:0]  hsize = 3'h2;
  logic [11:0] load_word = 0, nv_config_word, nv_calib_word;
  logic        master_clear_reset_pin_n = 1, ext_osc2 = 0, clock_output_function_src = 0, port_a_bit4_out = 0, port_a_bit4_oe = 0;
  logic        hreadyout, hresp, reset_timer_enable, brownout_reset_enable, selfwrite_memory_protect;
  logic        program_memory_protect, internal_osc_frequency_select, watchdog_enable, master_clear_reset;
  logic        port_a_bit3_in, osc2_out, osc2_oe, port_a_bit4_in, core_reset;
  logic [5:0]  clock_source_onehot;
  logic [6:0]  oscillator_trim;
  logic [9:0]  boot_pc;
  logic [7:0]  boot_accumulator;
  int          n_fail = 0, n_tests = 0;
  // Pin level: the device wins while it drives
  wire         osc2_in = osc2_oe ? osc2_out : ext_osc2;
  always #12.5 ref_clk = ~ref_clk;
  cwo_top #(.LONG_START_CYCLES(LONG_N)) dut (.ref_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .nv_config_word, .nv_calib_word, .reset_timer_enable,
    .brownout_reset_enable, .selfwrite_memory_protect, .program_memory_protect, .internal_osc_frequency_select,
    .watchdog_enable, .clock_source_onehot, .oscillator_trim, .master_clear_reset_pin_n, .master_clear_reset, .port_a_bit3_in,
    .osc2_in, .osc2_out, .osc2_oe, .clock_output_function_src, .port_a_bit4_out, .port_a_bit4_oe, .port_a_bit4_in, .core_reset,
    .boot_pc, .boot_accumulator);
  cwo_programmer #(.CALIB_WORD(CAL)) prog (.ref_clk, .load, .load_word, .erase, .config_word(nv_config_word),
    .calib_word(nv_calib_word));
  task automatic check(logic [31:0] seen, logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("Counts: %0d compares, %0d mismatches", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Bounded wait for hready; a hang ends the run
  task automatic edge_rdy();
    for (int i = 0; i < 20; i++) begin
      @(posedge ref_clk);
      if (hreadyout === 1'b1) return;
    end
    n_fail++;
    complete_run();
  endtask
  // Single word transfer, entered just after a rising edge
  task automatic bus(logic w, logic [31:0] a, logic [31:0] d, output logic [31:0] r);
    hsel <= 1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    edge_rdy();
    htrans <= 2'h0;
    hsel <= 0;
    hwdata <= d;
    edge_rdy();
    r = hrdata;
  endtask
  task automatic rd(logic [31:0] a, logic [31:0] e);
    logic [31:0] r;
    bus(0, a, 0, r);
    check(r, e);
  endtask
  task automatic reset_dut();
    @(posedge ref_clk) rst <= 1;
    repeat (2) @(posedge ref_clk);
    rst <= 0;
  endtask
  // Edges from release until the core runs
  task automatic boot(output int c);
    for (c = 1; c < 1000; c++) begin
      @(posedge ref_clk);
      #1;
      if (core_reset === 1'b0) return;
    end
    n_fail++;
    complete_run();
  endtask
  task automatic program_word(logic [11:0] w);
    @(posedge ref_clk) load <= 1;
    load_word <= w;
    @(posedge ref_clk) load <= 0;
  endtask
  initial begin
    int c;
    logic [11:0] cfg;
    logic [31:0] r;
    repeat (6) @(posedge ref_clk);
    rst <= 0;
    // Table of mode codes
    for (int i = 0; i < 8; i++) begin
      cfg = rows[i].cfg;
      program_word(cfg);
      reset_dut();
      boot(c);
      check(c >= rows[i].n && c <= rows[i].n + 8, 1);
      check(clock_source_onehot, rows[i].hot);
      check({reset_timer_enable, brownout_reset_enable}, cfg[9:8]);
      check({selfwrite_memory_protect, program_memory_protect}, {!cfg[7], !cfg[4]});
      check({internal_osc_frequency_select, watchdog_enable}, {cfg[6], cfg[3]});
      check({boot_pc, boot_accumulator}, {10'h000, CAL[7:0]});
      @(posedge ref_clk);
      rd(32'h0, {20'h0, 2'h3, cfg[9:0]});
      rd(32'h8, {21'h0, cfg[2:0], 2'h0, !cfg[4], !cfg[7], 1'b0, rows[i].n == LONG_N, 2'h1});
      rd(32'hC, {20'h0, CAL});
      rd(32'h10, {14'h0, 10'h000, CAL[7:0]});
      clock_output_function_src <= i[0];
      port_a_bit4_out <= !i[0];
      port_a_bit4_oe <= i[1];
      ext_osc2 <= !i[1];
      master_clear_reset_pin_n <= 0;
      @(posedge ref_clk);
      #1;
      if (cfg[2:0] < 3)
        check({osc2_oe, port_a_bit4_in}, 0);
      else if (cfg[2] && cfg[0])
        check({osc2_oe, osc2_out}, {1'b1, clock_output_function_src});
      else
        check({osc2_oe, osc2_out, port_a_bit4_in}, {port_a_bit4_oe, port_a_bit4_out,
          port_a_bit4_oe ? port_a_bit4_out : ext_osc2});
      check({master_clear_reset, core_reset, port_a_bit3_in}, {cfg[5], cfg[5], 1'b0});
      @(posedge ref_clk);
      #1;
      check(boot_pc, cfg[5] ? 10'h3FF : 10'h000);
      @(posedge ref_clk) master_clear_reset_pin_n <= 1;
      @(posedge ref_clk);
      #1;
      check(port_a_bit3_in, !cfg[5]);
    end
    // Blank word shows while reset is held
    @(posedge ref_clk) rst <= 1;
    repeat (2) @(posedge ref_clk);
    #1;
    check({clock_source_onehot, reset_timer_enable, program_memory_protect, core_reset, boot_pc, oscillator_trim},
      {6'h20, 1'b1, 1'b0, 1'b1, 10'h3FF, 7'h00});
    @(posedge ref_clk) rst <= 0;
    // Storage changed after release is not taken
    program_word(12'h001);
    repeat (3) @(posedge ref_clk);
    #1;
    check(clock_source_onehot, 6'h20);
    @(posedge ref_clk);
    bus(1, 32'h0, 32'h0, r);
    bus(1, 32'h4, 32'hFFFFFFFF, r);
    rd(32'h4, 32'hFE);
    #1;
    check(oscillator_trim, 7'h7F);
    @(posedge ref_clk);
    rd(32'h0, 32'hCE7);
    bus(1, 32'h4, 32'h55, r);
    rd(32'h4, 32'h54);
    rd(32'h20, 32'h0);
    rd(32'h1004, 32'h0);
    // Erase blanks the configuration word and keeps the calibration word
    @(posedge ref_clk) erase <= 1;
    @(posedge ref_clk) erase <= 0;
    reset_dut();
    boot(c);
    check(c >= LONG_N && c <= LONG_N + 8, 1);
    check({clock_source_onehot, boot_accumulator}, {6'h20, CAL[7:0]});
    complete_run();
  end
endmodule
